// ===== logic/gpc_regs.svh
/*
 Register indices, field positions, reset values and widths of the
 change-watch general-purpose port.
 Assumes the byte address of a register is four times its index, so the
 bus word address adr[11:2] is compared against the index directly.
*/
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// register indices (byte address = 4 * index)
`define GPC_IDX_PORT 10'h006
`define GPC_IDX_OPTION 10'h081
`define GPC_IDX_DIR 10'h086
`define GPC_IDX_ICTL 10'h00B
`define GPC_IDX_BSET 10'h0C0
`define GPC_IDX_BCLR 10'h0C1

// reset values
`define GPC_OPTION_RST 8'hFF
`define GPC_DIR_RST 8'hFF
`define GPC_LATCH_RST 8'h00
`define GPC_REF_RST 4'h0
`define GPC_PINS_RST 8'h00
`define GPC_OE_N_RST 8'hFF
`define GPC_PULLUP_RST 8'h00
`define GPC_WORD_RST 32'h0000_0000
`define GPC_SETTLE_RST 3'h0

// edges after reset before the synced pins can be trusted as a reference
`define GPC_SETTLE_CYC 3'h5

// field positions
`define GPC_PULLUP_BIT 7
`define GPC_FLAG_BIT 0
`define GPC_LVP_BIT 0
`define GPC_WATCH_HI 7
`define GPC_WATCH_LO 4
`define GPC_SEL_LANE0 0

// padding and fill constants
`define GPC_PAD_24 24'h00_0000
`define GPC_PAD_7 7'h00
`define GPC_LVP_MASK 4'h1
`define GPC_NONE_4 4'h0

`endif

// ===== logic/gpc_pkg.sv
/*
 Types shared by the change-watch port: Wishbone request and answer
 bundles, byte and nibble types.
 Assumes a 32-bit classic Wishbone bus with 12 byte-address bits.
*/
package gpc_pkg;

   typedef logic [7:0] gpc_byte_t;
   typedef logic [3:0] gpc_nib_t;
   typedef logic [9:0] gpc_idx_t;

   // master to slave bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } gpc_wb_req_s;

   // slave to master bundle
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } gpc_wb_rsp_s;

endpackage

// ===== logic/gpc_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs are asynchronous to clk_i; a new level is accepted only
 once stages two and three hold the same value.
*/
`timescale 1ns/1ns
module gpc_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;

   // stage one is read by stage two only, to keep metastability contained
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // per bit, take the level once the two settled stages agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lvl_q <= '0;
      end
      else
      begin
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_q[i] == s3_q[i])
            begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign level_o = lvl_q;

endmodule

// ===== logic/gpc_port.sv
/*
 Eight-bit bidirectional port with direction mask, output latch, shared
 weak pull-up control and change detection on the upper four pins,
 reached over a classic Wishbone slave.
 Assumes pins arrive asynchronously, alternate functions and sleep come
 from logic on clk_i, and the pin pad resolves level from pin_o and
 pin_oe_n_o (low = driving).
*/
`timescale 1ns/1ns
`include "gpc_regs.svh"
module gpc_port (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire gpc_pkg::gpc_wb_req_s wb_req_i,
   output gpc_pkg::gpc_wb_rsp_s wb_rsp_o,
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_n_o,
   output logic [7:0] pullup_on_o,
   input wire logic [7:0] alt_enable_i,
   input wire logic [7:0] alt_data_i,
   input wire logic [7:0] alt_drive_i,
   input wire logic low_volt_programming_i,
   input wire logic sleep_i,
   output logic [7:0] option_o,
   output logic change_flag_o,
   output logic wake_o
);

   // bus side
   logic ack_q;
   logic [31:0] rdat_q;
   logic go;
   logic wr;
   logic rd;
   logic lane0;
   gpc_pkg::gpc_idx_t idx;
   gpc_pkg::gpc_byte_t wbyte;

   // port state
   gpc_pkg::gpc_byte_t latch_q;
   gpc_pkg::gpc_byte_t dir_q;
   gpc_pkg::gpc_byte_t opt_q;
   gpc_pkg::gpc_byte_t pins;
   gpc_pkg::gpc_nib_t ref_q;
   logic ref_valid_q;
   logic flag_q;
   logic wake_q;

   // pad-facing registers
   gpc_pkg::gpc_byte_t pin_q;
   gpc_pkg::gpc_byte_t oe_n_q;
   gpc_pkg::gpc_byte_t pullup_q;

   // change detection
   gpc_pkg::gpc_nib_t watch;
   gpc_pkg::gpc_nib_t lvp_cut;
   logic mismatch;
   logic port_touch;
   logic flag_clr;
   logic flag_wr_set;
   logic [2:0] settle_q;
   logic settled;

   // pin levels pass four flops before anyone looks at them
   gpc_sync #(
      .WIDTH(8)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pin_i),
      .level_o(pins)
   );

   // classic cycle decode; one access per request, answered next cycle
   assign go = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
   assign wr = go & wb_req_i.we;
   assign rd = go & ~wb_req_i.we;
   assign idx = wb_req_i.adr[11:2];
   assign lane0 = wb_req_i.sel[`GPC_SEL_LANE0];
   assign wbyte = wb_req_i.dat[7:0];

   // ack rises one cycle after the strobe and drops the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= go;
      end
   end

   // read data registered at the strobe edge; unmapped reads give zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdat_q <= `GPC_WORD_RST;
      end
      else if (rd)
      begin
         case (idx)
            `GPC_IDX_PORT:
            begin
               rdat_q <= {`GPC_PAD_24, pins};
            end
            `GPC_IDX_OPTION:
            begin
               rdat_q <= {`GPC_PAD_24, opt_q};
            end
            `GPC_IDX_DIR:
            begin
               rdat_q <= {`GPC_PAD_24, dir_q};
            end
            `GPC_IDX_ICTL:
            begin
               rdat_q <= {`GPC_PAD_24, `GPC_PAD_7, flag_q};
            end
            default:
            begin
               rdat_q <= `GPC_WORD_RST;
            end
         endcase
      end
   end

   // one driver for the whole answer bundle
   assign wb_rsp_o = {ack_q, rdat_q};

   // output latch: plain write stores the byte, bit set and clear work
   // on the sampled pin levels, so an input bit copies its pin in
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_q <= `GPC_LATCH_RST;
      end
      else if (wr && lane0)
      begin
         case (idx)
            `GPC_IDX_PORT:
            begin
               latch_q <= wbyte;
            end
            `GPC_IDX_BSET:
            begin
               latch_q <= pins | wbyte;
            end
            `GPC_IDX_BCLR:
            begin
               latch_q <= pins & ~wbyte;
            end
            default:
            begin
               latch_q <= latch_q;
            end
         endcase
      end
   end

   // direction mask, all inputs out of reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dir_q <= `GPC_DIR_RST;
      end
      else if (wr && lane0 && idx == `GPC_IDX_DIR)
      begin
         dir_q <= wbyte;
      end
   end

   // option byte; only the pull-up bit is used here, the rest is passed on
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         opt_q <= `GPC_OPTION_RST;
      end
      else if (wr && lane0 && idx == `GPC_IDX_OPTION)
      begin
         opt_q <= wbyte;
      end
   end

   assign option_o = opt_q;

   // pad drive: the alternate function wins where enabled, else the mask
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_q <= `GPC_PINS_RST;
         oe_n_q <= `GPC_OE_N_RST;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (alt_enable_i[i])
            begin
               pin_q[i] <= alt_data_i[i];
               oe_n_q[i] <= ~alt_drive_i[i];
            end
            else
            begin
               pin_q[i] <= latch_q[i];
               oe_n_q[i] <= dir_q[i];
            end
         end
      end
   end

   // pull-ups: shared enable, dropped on outputs and, under low-voltage programming, on the program pin
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pullup_q <= `GPC_PULLUP_RST;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            pullup_q[i] <= ~opt_q[`GPC_PULLUP_BIT]
               & oe_n_q[i]
               & ~(low_volt_programming_i && i == `GPC_WATCH_LO);
         end
      end
   end

   assign pin_o = pin_q;
   assign pin_oe_n_o = oe_n_q;
   assign pullup_on_o = pullup_q;

   // only input pins of the upper nibble are watched; the program pin
   // drops out while low-voltage programming is configured
   assign lvp_cut = low_volt_programming_i ? `GPC_LVP_MASK : `GPC_NONE_4;
   assign watch = dir_q[`GPC_WATCH_HI:`GPC_WATCH_LO] & ~lvp_cut;
   assign mismatch = ref_valid_q &
      |((pins[`GPC_WATCH_HI:`GPC_WATCH_LO] ^ ref_q) & watch);

   // any port access, plain or bit operation, counts as a port touch
   assign port_touch = go &&
      (idx == `GPC_IDX_PORT || idx == `GPC_IDX_BSET ||
       idx == `GPC_IDX_BCLR);

   // the synchroniser leaves reset at zero, not at the real pin levels;
   // count the edges it needs so reset itself never looks like a change
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         settle_q <= `GPC_SETTLE_RST;
      end
      else if (settle_q != `GPC_SETTLE_CYC)
      begin
         settle_q <= 3'(settle_q + 3'h1);
      end
   end

   assign settled = (settle_q == `GPC_SETTLE_CYC);

   // reference tracks the synced pins until they have settled, then is
   // taken at every touch; a change seen on the touch edge still sets the flag
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ref_q <= `GPC_REF_RST;
         ref_valid_q <= 1'b0;
      end
      else if (!ref_valid_q || port_touch)
      begin
         ref_q <= pins[`GPC_WATCH_HI:`GPC_WATCH_LO];
         ref_valid_q <= settled;
      end
   end

   // software clears by writing 0 to bit 0, may set it by writing 1
   assign flag_clr = wr && lane0 && idx == `GPC_IDX_ICTL &&
      !wbyte[`GPC_FLAG_BIT];
   assign flag_wr_set = wr && lane0 && idx == `GPC_IDX_ICTL &&
      wbyte[`GPC_FLAG_BIT];

   // change flag: a live mismatch beats a clear in the same cycle, so the
   // handler must touch the port before clearing or the flag comes back
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flag_q <= 1'b0;
      end
      else if (mismatch || flag_wr_set)
      begin
         flag_q <= 1'b1;
      end
      else if (flag_clr)
      begin
         flag_q <= 1'b0;
      end
   end

   assign change_flag_o = flag_q;

   // wake request while asleep; the synced pins keep running in sleep
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wake_q <= 1'b0;
      end
      else
      begin
         wake_q <= sleep_i & (flag_q | mismatch);
      end
   end

   assign wake_o = wake_q;

endmodule

// ===== testbench/gpc_port_props.sv
/*
 Checker for the change-watch port, bound to gpc_port.
 Assumes the classic Wishbone timing and pad latencies of the port.
*/
`timescale 1ns/1ns
`include "gpc_regs.svh"
module gpc_port_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire gpc_pkg::gpc_wb_req_s wb_req_i,
   input wire gpc_pkg::gpc_wb_rsp_s wb_rsp_o,
   input wire logic [7:0] pin_i,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_n_o,
   input wire logic [7:0] pullup_on_o,
   input wire logic [7:0] alt_enable_i,
   input wire logic [7:0] alt_data_i,
   input wire logic [7:0] alt_drive_i,
   input wire logic low_volt_programming_i,
   input wire logic sleep_i,
   input wire logic [7:0] option_o,
   input wire logic change_flag_o,
   input wire logic wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   // a request is taken on any edge that sees it with ack low
   assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   // lane-0 write of one index, then a cycle with no alternate function
   sequence s_wr(idx);
      take && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr[11:2] == idx
      ##1 alt_enable_i == 8'h00;
   endsequence
   chk_ack_pulse: assert property (
      take |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
      else $error("ack is not a one cycle answer");
   chk_reset_vals: assert property (
      $past(rst_i) |-> option_o == 8'hFF && pin_oe_n_o == 8'hFF
      && pullup_on_o == 8'h00) else $error("reset values wrong");
   chk_dir_hiz: assert property (
      s_wr(`GPC_IDX_DIR) |=> pin_oe_n_o == $past(wb_req_i.dat[7:0], 2))
      else $error("driver enable does not follow direction");
   chk_latch_out: assert property (
      s_wr(`GPC_IDX_PORT) |=> ((pin_o ^ $past(wb_req_i.dat[7:0], 2))
      & ~pin_oe_n_o) == 8'h00) else $error("driven pin not latch");
   chk_pullup_out: assert property (
      $past(alt_enable_i) == 8'h00 && $past(alt_enable_i, 2) == 8'h00
      |-> (pullup_on_o & ~$past(pin_oe_n_o)) == 8'h00)
      else $error("pull-up on an output pin");
   chk_pullup_ctl: assert property (
      pullup_on_o != 8'h00 |-> !option_o[7] || !$past(option_o[7])
      || !$past(option_o[7], 2)) else $error("pull-up while disabled");
   chk_lvp_pin4: assert property (
      low_volt_programming_i && $past(low_volt_programming_i)
      |-> !pullup_on_o[4]) else $error("pin 4 pull-up under lvp");
   chk_flag_sticky: assert property (
      change_flag_o && !(take && wb_req_i.we
      && wb_req_i.adr[11:2] == `GPC_IDX_ICTL) |=> change_flag_o)
      else $error("change flag lost without a clear");
   chk_wake_flag: assert property (
      sleep_i && change_flag_o |=> wake_o) else $error("no wake");
   chk_no_wake: assert property (
      !sleep_i |=> !wake_o) else $error("wake while awake");
   chk_alt_dir: assert property (
      alt_enable_i != 8'h00 |=> ((pin_oe_n_o ^ ~$past(alt_drive_i))
      & $past(alt_enable_i)) == 8'h00) else $error("alt drive ignored");
endmodule

bind gpc_port gpc_port_props u_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_on_o(pullup_on_o),
   .alt_enable_i(alt_enable_i), .alt_data_i(alt_data_i),
   .alt_drive_i(alt_drive_i), .sleep_i(sleep_i), .option_o(option_o),
   .low_volt_programming_i(low_volt_programming_i),
   .change_flag_o(change_flag_o), .wake_o(wake_o));

// ===== testbench/gpc_pad.sv
/*
 Board model: pads, weak pull-ups and a key pad on eight pins.
 Assumes keys never fight a pin the port is driving.
*/
`timescale 1ns/1ns
module gpc_pad (
   input wire logic clk_i,
   input wire logic [7:0] drv_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] pullup_i,
   input wire logic [7:0] key_en_i,
   input wire logic [7:0] key_val_i,
   output logic [7:0] lvl_o
);
   logic [7:0] float_q = 8'h55;
   // an undriven pin toggles every edge, so the synchroniser never takes a level from it
   always_ff @(posedge clk_i)
      float_q <= ~float_q;
   // port drive wins, then keys, then pull-up, else floating
   assign lvl_o = (~oe_n_i & drv_i) | (oe_n_i & key_en_i & key_val_i)
      | (oe_n_i & ~key_en_i & (pullup_i | float_q));
endmodule

// ===== testbench/gpc_port_bench.sv
/*
 Self-checking bench for the change-watch port.
 Assumes gpc_pad on the pins and a 125 MHz clock.
*/
`timescale 1ns/1ns
`include "gpc_regs.svh"
module gpc_port_bench;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   gpc_pkg::gpc_wb_req_s req = '0;
   gpc_pkg::gpc_wb_rsp_s rsp;
   logic [7:0] pins, pin_o, oe_n, pu, opt, rd;
   logic [7:0] key_en = 8'hFF, key_val = 8'h30;
   logic [7:0] alt_en = 8'h00, alt_dat = 8'h00, alt_drv = 8'h00;
   logic low_volt_programming = 1'h0, slp = 1'h0, flag, wake;
   int bad_count = 0, comparisons = 0;

   gpc_port u_gpc_port (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .pin_i(pins), .pin_o(pin_o), .pin_oe_n_o(oe_n),
      .pullup_on_o(pu), .alt_enable_i(alt_en), .alt_data_i(alt_dat),
      .alt_drive_i(alt_drv), .low_volt_programming_i(low_volt_programming),
      .sleep_i(slp), .option_o(opt), .change_flag_o(flag),
      .wake_o(wake));
   gpc_pad u_gpc_pad (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(oe_n),
      .pullup_i(pu), .key_en_i(key_en), .key_val_i(key_val),
      .lvl_o(pins));

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   task automatic cmp(input string nm, input logic [7:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one classic cycle; waits for ack however long it takes
   task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
      req <= '{1'h1, 1'h1, w, {i, 2'h0}, 4'h1, {24'h0, d}};
      do @(posedge clk_i); while (rsp.ack !== 1'h1);
      rd = rsp.dat[7:0];
      req <= '0;
      @(posedge clk_i);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic t_reset;
      wb(1'h0, `GPC_IDX_OPTION, 8'h00);
      cmp("option", rd, 8'hFF);
      cmp("option pin", opt, 8'hFF);
      wb(1'h0, `GPC_IDX_DIR, 8'h00);
      cmp("dir", rd, 8'hFF);
      wb(1'h1, 10'h3FF, 8'hA5);
      wb(1'h0, 10'h3FF, 8'h00);
      cmp("unmapped", rd, 8'h00);
   endtask

   task automatic t_drive;
      wb(1'h1, `GPC_IDX_DIR, 8'hF0);
      wb(1'h1, `GPC_IDX_PORT, 8'hA5);
      wt(6);
      cmp("oe", oe_n, 8'hF0);
      cmp("drive", pin_o & 8'h0F, 8'h05);
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      cmp("pins", rd, 8'h35);
   endtask

   // set and clear use pin levels, so input bits land in the latch
   task automatic t_rmw;
      wb(1'h1, `GPC_IDX_BSET, 8'h02);
      wt(6);
      cmp("bset", pin_o & 8'h0F, 8'h07);
      wb(1'h1, `GPC_IDX_BCLR, 8'h04);
      wt(6);
      wb(1'h1, `GPC_IDX_DIR, 8'h00);
      wt(2);
      cmp("rmw", pin_o, 8'h33);
      wb(1'h1, `GPC_IDX_DIR, 8'hF0);
   endtask

   task automatic t_pullup;
      key_en <= 8'h00;
      wb(1'h1, `GPC_IDX_OPTION, 8'h7F);
      wt(4);
      cmp("pullup", pu, 8'hF0);
      cmp("option out", opt, 8'h7F);
      low_volt_programming <= 1'h1;
      wt(4);
      cmp("lvp pullup", pu, 8'hE0);
      low_volt_programming <= 1'h0;
      wt(6);
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      cmp("pulled", rd, 8'hF3);
      key_en <= 8'hFF;
      wt(6);
   endtask

   // a clear before a port read leaves the flag set; reading the port first lets it clear
   task automatic t_change;
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      wb(1'h1, `GPC_IDX_ICTL, 8'h00);
      cmp("idle", flag, 8'h00);
      key_val <= 8'h70;
      wt(8);
      cmp("set", flag, 8'h01);
      slp <= 1'h1;
      wt(2);
      cmp("wake", wake, 8'h01);
      slp <= 1'h0;
      wb(1'h1, `GPC_IDX_ICTL, 8'h00);
      cmp("kept", flag, 8'h01);
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      wb(1'h1, `GPC_IDX_ICTL, 8'h00);
      cmp("cleared", flag, 8'h00);
      low_volt_programming <= 1'h1;
      key_val <= 8'h60;
      wt(8);
      cmp("lvp watch", flag, 8'h00);
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      low_volt_programming <= 1'h0;
      wb(1'h1, `GPC_IDX_DIR, 8'h70);
      wb(1'h1, `GPC_IDX_PORT, 8'h80);
      wt(8);
      cmp("output pin", flag, 8'h00);
      // pin 7 turning back to input still shows its driven level against
      // the old reference, so refresh and clear before the next step
      wb(1'h1, `GPC_IDX_DIR, 8'hFF);
      wt(8);
      wb(1'h0, `GPC_IDX_PORT, 8'h00);
      wb(1'h1, `GPC_IDX_ICTL, 8'h00);
      key_val <= 8'h6F;
      wt(8);
      cmp("low pins", flag, 8'h00);
      wb(1'h1, `GPC_IDX_ICTL, 8'h01);
      wb(1'h0, `GPC_IDX_ICTL, 8'h00);
      cmp("flag read", rd, 8'h01);
      wb(1'h1, `GPC_IDX_ICTL, 8'h00);
      cmp("flag off", flag, 8'h00);
   endtask

   task automatic t_alt;
      alt_en <= 8'h01;
      alt_drv <= 8'h01;
      alt_dat <= 8'h01;
      wt(3);
      cmp("alt", pin_o & ~oe_n & 8'h01, 8'h01);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      t_reset;
      t_drive;
      t_rmw;
      t_pullup;
      t_change;
      t_alt;
      give_verdict;
   end

   // the whole run needs fewer than two hundred cycles
   initial
   begin
      repeat (3000) @(posedge clk_i);
      bad_count++;
      give_verdict;
   end
endmodule
